// ===== hpc_host_port.sv
// host port pin control with general purpose fallback
`timescale 1ns/100ps
`default_nettype none
module hpc_host_port (
   input  wire logic                       clk_sys,
   input  wire logic                       srst,
   input  wire logic [hpc_pkg::PIN_W-1:0]  pinIn,
   output logic      [hpc_pkg::PIN_W-1:0]  pinOut,
   output logic      [hpc_pkg::PIN_W-1:0]  pinOeN,
   input  wire logic                       cfgWe,
   input  wire logic                       cfgHostMode,
   input  wire logic [hpc_pkg::PIN_W-1:0]  cfgGpioDir,
   input  wire logic [hpc_pkg::PIN_W-1:0]  cfgGpioOut,
   output logic      [hpc_pkg::PIN_W-1:0]  gpioIn,
   output logic                            hostMode,
   input  wire logic                       svcRequest,
   output logic      [hpc_pkg::SEL_W-1:0]  rdSel,
   input  wire logic [hpc_pkg::DATA_W-1:0] rdData,
   output logic                            wrValid,
   input  wire logic                       wrReady,
   output logic      [hpc_pkg::SEL_W-1:0]  wrSel,
   output logic      [hpc_pkg::DATA_W-1:0] wrData
);
   localparam int unsigned DW = hpc_pkg::DATA_W;
   localparam int unsigned SW = hpc_pkg::SEL_W;
   localparam int unsigned D0 = hpc_pkg::PIN_DATA_LO;
   localparam int unsigned S0 = hpc_pkg::PIN_SEL_LO;

   hpc_pkg::hpc_state_t           state_r, state_nxt;
   logic                          mode_r, mode_nxt;
   logic [hpc_pkg::PIN_W-1:0]     dir_r, dir_nxt, gout_r, gout_nxt;
   logic [hpc_pkg::PIN_W-1:0]     gin_r, gin_nxt;
   logic [hpc_pkg::PIN_W-1:0]     out_r, out_nxt, oeN_r, oeN_nxt;
   logic [DW-1:0]                 hold_r, hold_nxt;
   logic [SW-1:0]                 selHold_r, selHold_nxt, rdSel_r, rdSel_nxt;
   logic                          enN, rw, ackN, reqOn, driveData, push, bufReady;
   logic [hpc_pkg::WORD_W-1:0]    bufOut;

   // host pin views
   assign enN  = pinIn[hpc_pkg::PIN_EN];
   assign rw   = pinIn[hpc_pkg::PIN_RW];
   assign ackN = pinIn[hpc_pkg::PIN_ACK];
   // request withheld while the buffer is full; a host write arriving then is not stored
   assign reqOn     = mode_r & svcRequest & bufReady;
   assign driveData = mode_r & ((!enN & rw) | (!ackN & reqOn));
   // write completes when enable rises after a write access
   assign push = (state_r == hpc_pkg::HPC_WRITE) & enN;

   // outputs
   assign pinOut   = out_r;
   assign pinOeN   = oeN_r;
   assign gpioIn   = gin_r;
   assign hostMode = mode_r;
   assign rdSel    = rdSel_r;
   assign wrSel    = bufOut[hpc_pkg::WORD_W-1:DW];
   assign wrData   = bufOut[DW-1:0];

   // configuration, access tracking and pin drive
   always_comb begin
      mode_nxt    = mode_r;
      dir_nxt     = dir_r;
      gout_nxt    = gout_r;
      gin_nxt     = pinIn;
      state_nxt   = state_r;
      hold_nxt    = hold_r;
      selHold_nxt = selHold_r;
      rdSel_nxt   = rdSel_r;
      if (cfgWe) begin
         mode_nxt = cfgHostMode;
         dir_nxt  = cfgGpioDir;
         gout_nxt = cfgGpioOut;
      end
      case (state_r)
         hpc_pkg::HPC_IDLE: begin
            if (mode_r && !enN) begin
               state_nxt = rw ? hpc_pkg::HPC_READ : hpc_pkg::HPC_WRITE;
            end
         end
         hpc_pkg::HPC_READ: begin
            if (enN || !mode_r) begin
               state_nxt = hpc_pkg::HPC_IDLE;
            end
         end
         hpc_pkg::HPC_WRITE: begin
            if (enN || !mode_r) begin
               state_nxt = hpc_pkg::HPC_IDLE;
            end
         end
         default: begin
            state_nxt = hpc_pkg::HPC_IDLE;
         end
      endcase
      // sample byte and select while the write strobe is low
      if (mode_r && !enN && !rw) begin
         hold_nxt    = pinIn[D0 +: DW];
         selHold_nxt = pinIn[S0 +: SW];
      end
      if (mode_r && !enN) begin
         rdSel_nxt = pinIn[S0 +: SW];
      end
      if (mode_r) begin
         out_nxt                   = '0;
         oeN_nxt                   = hpc_pkg::OEN_RST;
         out_nxt[D0 +: DW]         = rdData;
         oeN_nxt[D0 +: DW]         = {DW{!driveData}};
         oeN_nxt[hpc_pkg::PIN_REQ] = !reqOn;
      end else begin
         out_nxt = gout_r;
         oeN_nxt = ~dir_r;
      end
   end

   // register state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r   <= hpc_pkg::HPC_IDLE;
         mode_r    <= hpc_pkg::MODE_RST;
         dir_r     <= hpc_pkg::DIR_RST;
         gout_r    <= hpc_pkg::OUT_RST;
         gin_r     <= '0;
         out_r     <= hpc_pkg::OUT_RST;
         oeN_r     <= hpc_pkg::OEN_RST;
         hold_r    <= '0;
         selHold_r <= '0;
         rdSel_r   <= '0;
      end else begin
         state_r   <= state_nxt;
         mode_r    <= mode_nxt;
         dir_r     <= dir_nxt;
         gout_r    <= gout_nxt;
         gin_r     <= gin_nxt;
         out_r     <= out_nxt;
         oeN_r     <= oeN_nxt;
         hold_r    <= hold_nxt;
         selHold_r <= selHold_nxt;
         rdSel_r   <= rdSel_nxt;
      end
   end

   // written words toward the core
   hpc_word_buf #(
      .WIDTH (hpc_pkg::WORD_W),
      .DEPTH (hpc_pkg::BUF_DEPTH)
   ) u_buf (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .inValid  (push),
      .inReady  (bufReady),
      .inData   ({selHold_r, hold_r}),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  (bufOut)
   );

   // checks
   property p_idleFloat;
      @(posedge clk_sys) disable iff (srst)
      (mode_r && enN && !(!ackN && reqOn)) |=> (pinOeN[D0 +: DW] == 8'hFF);
   endproperty
   a_idleFloat: assert property (p_idleFloat) else $error("data driven while enable idle");

   property p_readDrive;
      @(posedge clk_sys) disable iff (srst)
      (mode_r && !enN && rw) |=> (pinOeN[D0 +: DW] == 8'h00 && pinOut[D0 +: DW] == $past(rdData));
   endproperty
   a_readDrive: assert property (p_readDrive) else $error("read not driven");

   property p_ackDrive;
      @(posedge clk_sys) disable iff (srst)
      (!ackN && reqOn) |=> (pinOeN[D0 +: DW] == 8'h00);
   endproperty
   a_ackDrive: assert property (p_ackDrive) else $error("acknowledge did not drive data");

   property p_writeInput;
      @(posedge clk_sys) disable iff (srst)
      (mode_r && !enN && !rw && ackN) |=> (pinOeN[D0 +: DW] == 8'hFF);
   endproperty
   a_writeInput: assert property (p_writeInput) else $error("data driven during write");

   property p_writeCapture;
      @(posedge clk_sys) disable iff (srst)
      (mode_r && !enN && !rw) ##1 (state_r == hpc_pkg::HPC_WRITE && enN)
         |-> (push && {selHold_r, hold_r} == {$past(pinIn[S0 +: SW]), $past(pinIn[D0 +: DW])});
   endproperty
   a_writeCapture: assert property (p_writeCapture) else $error("write byte not captured at rising enable");

   property p_selTrack;
      @(posedge clk_sys) disable iff (srst)
      (mode_r && !enN) |=> (rdSel == $past(pinIn[S0 +: SW]));
   endproperty
   a_selTrack: assert property (p_selTrack) else $error("register select not taken");

   property p_gpioPass;
      @(posedge clk_sys) disable iff (srst)
      !mode_r |=> (pinOeN == ~$past(dir_r) && pinOut == $past(gout_r));
   endproperty
   a_gpioPass: assert property (p_gpioPass) else $error("gpio pins not independent");

   property p_resetInput;
      @(posedge clk_sys) $past(srst) |-> (pinOeN == 15'h7FFF && !hostMode);
   endproperty
   a_resetInput: assert property (p_resetInput) else $error("pins not inputs after reset");

   property p_reqOpenDrain;
      @(posedge clk_sys) disable iff (srst)
      mode_r |=> (pinOut[hpc_pkg::PIN_REQ] == 1'b0 && pinOeN[hpc_pkg::PIN_REQ] == !$past(reqOn));
   endproperty
   a_reqOpenDrain: assert property (p_reqOpenDrain) else $error("request not open drain");

   property p_modeSet;
      @(posedge clk_sys) disable iff (srst)
      cfgWe |=> (hostMode == $past(cfgHostMode));
   endproperty
   a_modeSet: assert property (p_modeSet) else $error("mode setting not applied");
endmodule : hpc_host_port
`default_nettype wire

// ===== hpc_pkg.sv
// constants for the host port pin controller
package hpc_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned SEL_W      = 3;
   localparam int unsigned PIN_W      = 15;
   localparam int unsigned WORD_W     = DATA_W + SEL_W;
   localparam int unsigned BUF_DEPTH  = 2;
   // pin positions on the shared port
   localparam int unsigned PIN_DATA_LO = 0;
   localparam int unsigned PIN_SEL_LO  = 8;
   localparam int unsigned PIN_RW      = 11;
   localparam int unsigned PIN_EN      = 12;
   localparam int unsigned PIN_REQ     = 13;
   localparam int unsigned PIN_ACK     = 14;
   // reset values
   localparam logic             MODE_RST = 1'b0;
   localparam logic [PIN_W-1:0] DIR_RST  = 15'h0000;
   localparam logic [PIN_W-1:0] OUT_RST  = 15'h0000;
   localparam logic [PIN_W-1:0] OEN_RST  = 15'h7FFF;
   // access state, gray coded along idle, read, write
   typedef enum logic [1:0] {
      HPC_IDLE = 2'b00,
      HPC_READ = 2'b01,
      HPC_WRITE = 2'b11
   } hpc_state_t;
endpackage : hpc_pkg

// ===== hpc_word_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module hpc_word_buf #(
   parameter int unsigned WIDTH = 11,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   // handshake terms
   // count is one bit wider than the pointers so the full value fits
   assign inReady  = (cnt_r != (PW + 1)'(DEPTH));
   assign outValid = (cnt_r != '0);
   assign outData  = mem_r[rp_r];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // next pointers, count and storage
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = inData;
         wp_nxt        = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // register state
   always_ff @(posedge clk_sys) begin
      mem_r <= mem_nxt;
      if (srst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule : hpc_word_buf
`default_nettype wire

// ===== hpc_host_model.sv
// host processor model driving the shared port pins
`timescale 1ns/100ps
`default_nettype none
module hpc_host_model (
   input  wire logic        clk_sys,
   input  wire logic [14:0] pinWire,
   output logic      [14:0] hostOut,
   output logic      [14:0] hostOeN
);
   // idle: enable and acknowledge held high, everything else released
   initial begin
      hostOut = 15'h5000;
      hostOeN = 15'h2FFF;
   end
   // static pin drive for gpio and acknowledge cases
   task automatic drive(input logic [14:0] v, input logic [14:0] oeN);
      @(posedge clk_sys);
      hostOut <= v;
      hostOeN <= oeN;
   endtask : drive
   // one host access; select and direction stay put while enable is low
   task automatic access(input logic rw, input logic [2:0] sel, input logic [7:0] d, output logic [7:0] rd);
      @(posedge clk_sys);
      hostOut <= {1'b1, 1'b0, 1'b0, rw, sel, d};
      hostOeN <= rw ? 15'h20FF : 15'h2000;
      repeat (4) @(posedge clk_sys);
      rd = pinWire[7:0];
      hostOut[12] <= 1'b1;
      @(posedge clk_sys);
      hostOut <= 15'h5000;
      hostOeN <= 15'h2FFF;
      repeat (2) @(posedge clk_sys);
   endtask : access
endmodule : hpc_host_model
`default_nettype wire

// ===== test_host_port_pin_control.sv
// testbench for the host port pin controller
`timescale 1ns/100ps
`default_nettype none
module test_host_port_pin_control;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [14:0] pinWire, pinOut, pinOeN, gpioIn, hostOut, hostOeN, cfgGpioDir, cfgGpioOut;
   logic [14:0] flt_r = 15'h1555;
   logic        cfgWe = 1'b0, cfgHostMode = 1'b0, svcRequest = 1'b0, wrReady = 1'b0;
   logic        hostMode, wrValid;
   logic [2:0]  rdSel, wrSel;
   logic [7:0]  rdData, wrData, rd;
   logic [11:0] rows [6] = '{12'hF00, 12'h2A5, 12'h800, 12'h75A, 12'hB00, 12'h0FF};
   int          failures = 0, checks_done = 0;
   always #2.5 clk_sys = ~clk_sys;
   // released lines toggle, request and acknowledge are pulled high
   always @(posedge clk_sys) flt_r <= {2'b11, ~flt_r[12:0]};
   assign pinWire = (~pinOeN & pinOut) | (pinOeN & ~hostOeN & hostOut) | (pinOeN & hostOeN & flt_r);
   assign rdData  = 8'hC3 ^ {5'h00, rdSel};
   initial begin
      cfgGpioDir = 15'h0000;
      cfgGpioOut = 15'h0000;
   end
   hpc_host_port u_hpc_host_port (.clk_sys(clk_sys), .srst(srst), .pinIn(pinWire), .pinOut(pinOut),
      .pinOeN(pinOeN), .cfgWe(cfgWe), .cfgHostMode(cfgHostMode), .cfgGpioDir(cfgGpioDir),
      .cfgGpioOut(cfgGpioOut), .gpioIn(gpioIn), .hostMode(hostMode), .svcRequest(svcRequest),
      .rdSel(rdSel), .rdData(rdData), .wrValid(wrValid), .wrReady(wrReady), .wrSel(wrSel), .wrData(wrData));
   hpc_host_model u_hpc_host_model (.clk_sys(clk_sys), .pinWire(pinWire), .hostOut(hostOut), .hostOeN(hostOeN));
   // comparisons of vectors and of flags
   task automatic chkVec(input logic [14:0] got, input logic [14:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: vector got %h exp %h", $time, got, exp);
      end
   endtask : chkVec
   task automatic chkBit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: flag got %b exp %b", $time, got, exp);
      end
   endtask : chkBit
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // configuration load
   task automatic cfg(input logic m, input logic [14:0] dir, input logic [14:0] v);
      @(posedge clk_sys);
      cfgWe <= 1'b1;
      cfgHostMode <= m;
      cfgGpioDir <= dir;
      cfgGpioOut <= v;
      @(posedge clk_sys);
      cfgWe <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : cfg
   // wait for a written word, compare it, pop it
   task automatic drain(input logic [2:0] s, input logic [7:0] d);
      int n;
      n = 0;
      while (wrValid !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chkBit(wrValid, 1'b1);
      chkVec({7'h00, wrData}, {7'h00, d});
      chkVec({12'h000, wrSel}, {12'h000, s});
      @(posedge clk_sys);
      wrReady <= 1'b1;
      @(posedge clk_sys);
      wrReady <= 1'b0;
      #1;
   endtask : drain
   // watchdog
   initial begin
      #100000;
      failures++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chkVec(pinOeN, 15'h7FFF);
      chkBit(hostMode, 1'b0);
      // gpio mode: low byte out, upper pins in
      u_hpc_host_model.drive(15'h5A00, 15'h00FF);
      cfg(1'b0, 15'h00FF, 15'h00A5);
      @(posedge clk_sys);
      #1;
      chkVec(pinOeN, 15'h7F00);
      chkVec(pinOut, 15'h00A5);
      chkVec(gpioIn, 15'h5AA5);
      u_hpc_host_model.drive(15'h5000, 15'h2FFF);
      cfg(1'b1, 15'h0000, 15'h0000);
      chkBit(hostMode, 1'b1);
      chkVec(pinOeN, 15'h7FFF);
      // ordinary reads and writes
      foreach (rows[i]) begin
         u_hpc_host_model.access(rows[i][11], rows[i][10:8], rows[i][7:0], rd);
         #1;
         if (rows[i][11]) begin
            chkVec({7'h00, rd}, {7'h00, 8'hC3 ^ {5'h00, rows[i][10:8]}});
         end else begin
            drain(rows[i][10:8], rows[i][7:0]);
         end
         chkVec(pinOeN, 15'h7FFF);
      end
      // request and acknowledge
      @(posedge clk_sys);
      svcRequest <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chkVec(pinOeN, 15'h5FFF);
      chkBit(pinOut[13], 1'b0);
      u_hpc_host_model.drive(15'h1000, 15'h2FFF);
      repeat (2) @(posedge clk_sys);
      #1;
      chkVec({7'h00, pinOeN[7:0]}, 15'h0000);
      u_hpc_host_model.drive(15'h5000, 15'h2FFF);
      // two writes while the receiver stalls fill the buffer
      u_hpc_host_model.access(1'b0, 3'h1, 8'h3C, rd);
      u_hpc_host_model.access(1'b0, 3'h6, 8'hE7, rd);
      #1;
      chkBit(pinOeN[13], 1'b1);
      drain(3'h1, 8'h3C);
      repeat (2) @(posedge clk_sys);
      #1;
      chkBit(pinOeN[13], 1'b0);
      drain(3'h6, 8'hE7);
      chkBit(wrValid, 1'b0);
      report_and_stop;
   end
endmodule : test_host_port_pin_control
`default_nettype wire
